//--- core/pec_pkg.sv
// Constants, carriers and state layout for the PHY event interrupt and counter registers
package pec_pkg;
    // ==========================================================
    // Register map (management register numbers)
    localparam logic [4:0] REG_IRQ = 5'h15;
    localparam logic [4:0] REG_RXERR = 5'h16;
    localparam logic [4:0] REG_DISC = 5'h17;
    localparam logic [4:0] REG_STRAP = 5'h18;

    // ==========================================================
    // Field positions and reset values
    localparam int PEND_BIT = 15;
    localparam int MASK_LSB = 8;
    localparam int FLAG_LSB = 2;
    localparam int STAT_BIT = 0;
    localparam int STRAP_W = 14;
    localparam int PHYAD_W = 5;
    localparam logic [3:0] MASK_RST = 4'hf;

    // ==========================================================
    // Management frame counts
    localparam logic [4:0] PRE_ONES = 5'h1f;
    localparam logic [4:0] HDR_LAST = 5'h0b;
    localparam logic [4:0] TA_LAST = 5'h01;
    localparam logic [4:0] DATA_LAST = 5'h0f;
    localparam logic [4:0] DATA_END = 5'h10;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] STRAP_AT = 2'h2;
    localparam logic [1:0] STRAP_DONE = 2'h3;

    typedef enum logic [2:0] {
        MS_IDLE,
        MS_START,
        MS_HDR,
        MS_TA_RD,
        MS_RD,
        MS_TA_WR,
        MS_WR
    } pec_mstate_t;

    // Status from the transceiver core, same clock domain
    typedef struct packed {
        logic link_up;
        logic speed_100;
        logic full_dpx;
        logic rx_err;
        logic disconnect;
    } pec_evt_t;

    // flags: {duplex, speed, link}; masks: {duplex, speed, link, master}
    typedef struct packed {
        logic [1:0] mdc_s;
        logic [1:0] mdio_s;
        logic mdc_prev;
        pec_mstate_t st;
        logic [4:0] cnt;
        logic pre_ok;
        logic [15:0] sh;
        logic [4:0] ra;
        logic hit;
        logic mdio_o;
        logic mdio_oe;
        logic primed;
        logic [2:0] prev;
        logic [2:0] flags;
        logic [3:0] masks;
        logic irq_n;
        logic [15:0] rxerr;
        logic [7:0] disc;
        logic [STRAP_W-1:0] strap_s1;
        logic [STRAP_W-1:0] strap_s2;
        logic [1:0] strap_cnt;
        logic [STRAP_W-1:0] strap;
    } pec_state_t;
endpackage

//--- core/pec_phy_event_regs.sv
// Management-reachable event interrupt, error counters and strap latch of the transceiver
// Operation
// - Interrupt register top bit copies status bit zero; cleared by the read.
// - Duplex mask set blocks interrupts from duplex changes; resets to one.
// - Speed mask set blocks interrupts from speed changes; resets to one.
// - Link mask set blocks interrupts from link changes; resets to one.
// - Master mask set, its reset value, blocks every interrupt.
// - Duplex change latches high; a read of the interrupt register clears it.
// - Speed change latches high; a read of the interrupt register clears it.
// - Link change latches high; a read of the interrupt register clears it.
// - Status bit mirrors interrupt pin: master off and an unmasked flag set.
// - Sixteen-bit read-only receive error counter, reset zero, counts each error.
// - Eight-bit read-only disconnect counter in low byte; upper byte reads zero.
// - Fourteen strap pin levels captured at hardware reset into bits 13..0.
`timescale 1ns/1ps
module pec_phy_event_regs
    import pec_pkg::*;
(
    input wire logic clk_i, // 10 MHz device clock
    input wire logic rst_n_i, // Asynchronous hardware reset
    input wire pec_evt_t evt_i, // Core link state and event pulses
    input wire logic [STRAP_W-1:0] strap_i, // Strap pin levels
    input wire logic mdc_i, // Management clock pin
    input wire logic mdio_i, // Management data pin, input side
    output logic mdio_o, // Management data pin, output value
    output logic mdio_oe_o, // Management data pin, drive enable
    output logic mgmt_irq_out_n_o // Interrupt pin, active low
);
    pec_state_t q;
    pec_state_t d;
    logic rise;
    logic mbit;
    logic rd_clr;
    logic [2:0] chg;
    logic irq_stat;

    // ==========================================================
    // Helpers
    function automatic logic irq_status(pec_state_t s);
        irq_status = ~s.masks[0] & (|(s.flags & ~s.masks[3:1]));
    endfunction

    function automatic logic [15:0] read_word(pec_state_t s, logic [4:0] ra);
        logic st;
        st = irq_status(s);
        case (ra)
            REG_IRQ: read_word = {st, 3'h0, s.masks, 3'h0, s.flags, 1'b0, st};
            REG_RXERR: read_word = s.rxerr;
            REG_DISC: read_word = {8'h00, s.disc};
            REG_STRAP: read_word = {2'h0, s.strap};
            default: read_word = 16'h0000;
        endcase
    endfunction

    // Edges of the management clock are found on the synchronised copy only
    assign rise = q.mdc_s[1] & ~q.mdc_prev;
    assign mbit = q.mdio_s[1];
    assign irq_stat = irq_status(q);

    // ==========================================================
    // Next state
    always_comb begin
        logic [11:0] hdr;
        logic [15:0] wdat;
        hdr = {q.sh[10:0], mbit};
        wdat = {q.sh[14:0], mbit};
        d = q;
        rd_clr = 1'b0;
        d.mdc_s = {q.mdc_s[0], mdc_i};
        d.mdio_s = {q.mdio_s[0], mdio_i};
        d.mdc_prev = q.mdc_s[1];
        d.strap_s1 = strap_i;
        d.strap_s2 = q.strap_s1;
        // Straps are taken once the synchroniser has filled after release
        if (q.strap_cnt != STRAP_DONE) begin
            d.strap_cnt = q.strap_cnt + 2'h1;
        end
        if (q.strap_cnt == STRAP_AT) begin
            d.strap = q.strap_s2;
        end

        if (rise) begin
            case (q.st)
                MS_IDLE: begin
                    d.mdio_oe = 1'b0;
                    if (mbit) begin
                        d.cnt = (q.cnt == PRE_ONES) ? PRE_ONES : q.cnt + 5'h01;
                        d.pre_ok = (q.cnt == PRE_ONES);
                    end else begin
                        d.st = q.pre_ok ? MS_START : MS_IDLE;
                        d.cnt = 5'h00;
                        d.pre_ok = 1'b0;
                    end
                end
                MS_START: begin
                    d.st = mbit ? MS_HDR : MS_IDLE;
                    d.cnt = 5'h00;
                end
                MS_HDR: begin
                    d.sh = {q.sh[14:0], mbit};
                    d.cnt = q.cnt + 5'h01;
                    if (q.cnt == HDR_LAST) begin
                        d.cnt = 5'h00;
                        d.ra = hdr[4:0];
                        // Address arrives MSB first, compared with strapped address
                        d.hit = (hdr[9:5] == q.strap[PHYAD_W-1:0]);
                        if (hdr[11:10] == OP_READ && d.hit) begin
                            d.sh = read_word(q, hdr[4:0]);
                            rd_clr = (hdr[4:0] == REG_IRQ);
                            d.st = MS_TA_RD;
                        end else if (hdr[11:10] == OP_WRITE) begin
                            d.st = MS_TA_WR;
                        end else begin
                            d.st = MS_IDLE;
                        end
                    end
                end
                MS_TA_RD: begin
                    d.mdio_oe = 1'b1;
                    d.mdio_o = 1'b0;
                    d.st = MS_RD;
                end
                MS_RD: begin
                    if (q.cnt == DATA_END) begin
                        d.mdio_oe = 1'b0;
                        d.mdio_o = 1'b0;
                        d.cnt = 5'h00;
                        d.st = MS_IDLE;
                    end else begin
                        d.mdio_o = q.sh[15];
                        d.sh = {q.sh[14:0], 1'b0};
                        d.cnt = q.cnt + 5'h01;
                    end
                end
                MS_TA_WR: begin
                    d.cnt = (q.cnt == TA_LAST) ? 5'h00 : q.cnt + 5'h01;
                    d.st = (q.cnt == TA_LAST) ? MS_WR : MS_TA_WR;
                end
                MS_WR: begin
                    d.sh = wdat;
                    d.cnt = q.cnt + 5'h01;
                    if (q.cnt == DATA_LAST) begin
                        // Only the mask field is writable anywhere in the map
                        if (q.hit && q.ra == REG_IRQ) begin
                            d.masks = wdat[MASK_LSB+3:MASK_LSB];
                        end
                        d.cnt = 5'h00;
                        d.st = MS_IDLE;
                    end
                end
                default: begin
                    d.st = MS_IDLE;
                    d.mdio_oe = 1'b0;
                end
            endcase
        end

        // First sample after reset only primes; avoids a false change
        d.primed = 1'b1;
        d.prev = {evt_i.full_dpx, evt_i.speed_100, evt_i.link_up};
        chg = q.primed ? (d.prev ^ q.prev) : 3'h0;
        // A change in the clearing cycle survives the clear
        d.flags = (rd_clr ? 3'h0 : q.flags) | chg;
        d.irq_n = ~irq_stat;
        if (evt_i.rx_err) begin
            d.rxerr = q.rxerr + 16'h0001;
        end
        if (evt_i.disconnect) begin
            d.disc = q.disc + 8'h01;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '0;
            q.st <= MS_IDLE;
            q.masks <= MASK_RST;
            q.irq_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign mdio_o = q.mdio_o;
    assign mdio_oe_o = q.mdio_oe;
    assign mgmt_irq_out_n_o = q.irq_n;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    chk_pin_low_on: assert property (irq_stat |=> !mgmt_irq_out_n_o)
        else $error("interrupt pin not low after status set");
    chk_pin_follows: assert property (!irq_stat |=> mgmt_irq_out_n_o)
        else $error("interrupt pin low without status");
    chk_master_mask: assert property (q.masks[0] |-> !irq_stat ##1 mgmt_irq_out_n_o)
        else $error("interrupt raised under master mask");
    chk_duplex_mask: assert property ((q.masks[3] && q.flags == 3'h4) |-> !irq_stat)
        else $error("masked duplex change raised interrupt");
    chk_speed_mask: assert property ((q.masks[2] && q.flags == 3'h2) |-> !irq_stat)
        else $error("masked speed change raised interrupt");
    chk_link_mask: assert property ((q.masks[1] && q.flags == 3'h1) |-> !irq_stat)
        else $error("masked link change raised interrupt");
    chk_duplex_latch: assert property ((q.primed && evt_i.full_dpx != q.prev[2])
        |=> q.flags[2] ##1 (q.flags[2] || $past(rd_clr)))
        else $error("duplex change not latched");
    chk_speed_latch: assert property ((q.primed && evt_i.speed_100 != q.prev[1])
        |=> q.flags[1])
        else $error("speed change not latched");
    chk_link_latch: assert property ((q.primed && evt_i.link_up != q.prev[0])
        |=> q.flags[0])
        else $error("link change not latched");
    chk_read_clears: assert property ((rd_clr && chg == 3'h0) |=> q.flags == 3'h0)
        else $error("interrupt read did not clear flags");
    chk_pend_copy: assert property (rd_clr |=> q.sh[PEND_BIT] == q.sh[STAT_BIT])
        else $error("pending bit differs from status bit");
    chk_reserved_zero: assert property (rd_clr |=> (q.sh[14:12] == 3'h0
        && q.sh[7:5] == 3'h0 && !q.sh[1]))
        else $error("reserved interrupt bits not zero");
    chk_rxerr_count: assert property (evt_i.rx_err |=> q.rxerr == $past(q.rxerr) + 16'h0001)
        else $error("receive error counter did not advance");
    chk_disc_count: assert property (evt_i.disconnect |=> q.disc == $past(q.disc) + 8'h01)
        else $error("disconnect counter did not advance");
    chk_strap_hold: assert property ((q.strap_cnt == STRAP_DONE) |=> $stable(q.strap))
        else $error("strap latch changed after capture");

    cov_irq_read: cover property (rd_clr && irq_stat);
    cov_mask_write: cover property (rise && q.st == MS_WR && q.cnt == DATA_LAST && q.hit);
    cov_irq_pin: cover property (!mgmt_irq_out_n_o);
    cov_read_data: cover property (q.st == MS_RD && q.cnt == DATA_END && rise);
endmodule

//--- bench/pec_sta_model.sv
// Station management model: drives the management clock and read and write frames
`timescale 1ns/1ps
module pec_sta_model (
    input wire logic mdio_i, // Resolved data line
    output logic mdc_o, // Management clock, still between frames
    output logic mdio_o, // Data driven by the station
    output logic mdio_oe_o // Station drives the data line
);
    initial begin
        mdc_o = 1'b0;
        mdio_o = 1'b0;
        mdio_oe_o = 1'b0;
    end

    // ==========================================================
    // Bit timing
    // Data only changes while the clock is low, which keeps setup and hold wide
    // Nonblocking updates keep pin changes behind the device clock's sampling
    task automatic tick(output logic s);
        #400 mdc_o <= 1'b1;
        s = mdio_i;
        #400 mdc_o <= 1'b0;
    endtask

    task automatic put(input logic b);
        logic s;
        mdio_o <= b;
        mdio_oe_o <= 1'b1;
        tick(s);
    endtask

    // ==========================================================
    // Frames
    task automatic frame(input logic wr, input logic [4:0] phy, input logic [4:0] ra,
            input logic [15:0] wd, output logic [15:0] rd, output logic ta);
        logic [13:0] hdr;
        logic s;
        rd = 16'h0000;
        ta = 1'b0;
        hdr = {2'b01, (wr ? 2'b01 : 2'b10), phy, ra};
        repeat (32) put(1'b1);
        for (int i = 13; i >= 0; i--) put(hdr[i]);
        if (wr) begin
            put(1'b1);
            put(1'b0);
            for (int i = 15; i >= 0; i--) put(wd[i]);
        end else begin
            // Release before the turnaround so the device can take the line
            mdio_oe_o <= 1'b0;
            tick(s);
            tick(ta);
            for (int i = 15; i >= 0; i--) begin
                tick(s);
                rd[i] = s;
            end
        end
        mdio_oe_o <= 1'b0;
    endtask
endmodule

//--- bench/pec_phy_event_regs_tb.sv
// Self-checking bench for the event interrupt, counter and strap registers
`timescale 1ns/1ps
module pec_phy_event_regs_tb;
    import pec_pkg::*;
    logic clk_i;
    logic rst_n_i;
    pec_evt_t evt_i;
    logic [STRAP_W-1:0] strap_i;
    logic mdc;
    logic sta_d;
    logic sta_oe;
    logic dev_d;
    logic dev_oe;
    logic irq_n;
    wire logic mdio_w;
    int num_errors = 0;
    int n_compared = 0;
    logic [15:0] seed;
    logic [15:0] rd;
    logic [15:0] w;
    logic ta;
    logic [4:0] phy;
    logic [3:0] m;
    logic [2:0] t;
    logic [15:0] n_rx;
    logic [7:0] n_dc;

    // Pull-up on the shared data line
    assign mdio_w = dev_oe ? dev_d : (sta_oe ? sta_d : 1'b1);

    pec_phy_event_regs DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .evt_i(evt_i),
        .strap_i(strap_i), .mdc_i(mdc), .mdio_i(mdio_w), .mdio_o(dev_d),
        .mdio_oe_o(dev_oe), .mgmt_irq_out_n_o(irq_n));
    pec_sta_model sta (.mdio_i(mdio_w), .mdc_o(mdc), .mdio_o(sta_d), .mdio_oe_o(sta_oe));

    // ==========================================================
    // Helpers
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic logic [15:0] irq_word(input logic [3:0] mk, input logic [2:0] fl);
        logic st;
        st = !mk[0] && (|(fl & ~mk[3:1]));
        return {st, 3'b000, mk, 3'b000, fl, 1'b0, st};
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t: bit got %b expected %b", $time, got, exp);
        end
    endtask

    task automatic frm(input logic wr, input logic [4:0] p, input logic [4:0] ra,
            input logic [15:0] wd);
        // Let two device clock edges pass so no model line is set twice in one step
        repeat (2) @(posedge clk_i);
        sta.frame(wr, p, ra, wd, rd, ta);
    endtask

    task automatic rdr(input logic [4:0] ra, output logic [15:0] d);
        frm(1'b0, phy, ra, 16'h0000);
        d = rd;
        chk_bit(ta, 1'b0);
    endtask

    task automatic wrr(input logic [4:0] ra, input logic [15:0] wd);
        frm(1'b1, phy, ra, wd);
    endtask

    task automatic end_of_test;
        $display("Compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Clock, watchdog, main sequence
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    initial begin
        #6_000_000;
        num_errors++;
        end_of_test();
    end

    initial begin
        seed = lfsr(16'h0013);
        strap_i = seed[13:0];
        phy = seed[4:0];
        evt_i = '0;
        rst_n_i = 1'b0;
        n_rx = 16'h0000;
        n_dc = 8'h00;
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        rdr(REG_STRAP, rd);
        chk(rd, {2'b00, strap_i});
        rdr(REG_IRQ, rd);
        chk(rd, 16'h0f00);
        rdr(5'h1f, rd);
        chk(rd, 16'h0000);
        frm(1'b0, phy ^ 5'h01, REG_IRQ, 16'h0000);
        chk(rd, 16'hffff);
        chk_bit(ta, 1'b1);
        frm(1'b1, phy ^ 5'h01, REG_IRQ, 16'h0000);
        rdr(REG_IRQ, rd);
        chk(rd, 16'h0f00);
        wrr(REG_RXERR, 16'h1234);
        for (int k = 0; k < 12; k++) begin
            seed = lfsr(seed);
            // First two passes: master mask alone, then everything unmasked
            m = (k == 0) ? 4'h1 : ((k == 1) ? 4'h0 : seed[3:0]);
            t = (k < 2) ? 3'b111 : seed[6:4];
            wrr(REG_IRQ, {seed[15:12], m, seed[11:4]});
            @(posedge clk_i);
            evt_i.link_up <= evt_i.link_up ^ t[0];
            evt_i.speed_100 <= evt_i.speed_100 ^ t[1];
            evt_i.full_dpx <= evt_i.full_dpx ^ t[2];
            evt_i.rx_err <= seed[7];
            evt_i.disconnect <= seed[8];
            @(posedge clk_i);
            evt_i.rx_err <= 1'b0;
            evt_i.disconnect <= 1'b0;
            n_rx = n_rx + {15'h0000, seed[7]};
            n_dc = n_dc + {7'h00, seed[8]};
            repeat (4) @(posedge clk_i);
            w = irq_word(m, t);
            chk_bit(irq_n, ~w[0]);
            rdr(REG_IRQ, rd);
            chk(rd, w);
            repeat (4) @(posedge clk_i);
            chk_bit(irq_n, 1'b1);
            rdr(REG_IRQ, rd);
            chk(rd, irq_word(m, 3'b000));
        end
        rdr(REG_RXERR, rd);
        chk(rd, n_rx);
        rdr(REG_DISC, rd);
        chk(rd, {8'h00, n_dc});
        end_of_test();
    end
endmodule
